// [port_input_and_edge_select.v]
// Port 3 pin state, weak pullup control and external interrupt edge select.
// Assumes a classic Wishbone master on clk_i and asynchronous external pins.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "port_edge_consts.vh"

// Function
// - Port 3 read returns pin levels, read-only
// - Input pin with latch one: pullup on
// - Input pin with latch zero: high impedance
// - Low polarity register clears on reset
// - Lines 0-7: zero rising, one falling
// - High polarity register clears on reset
// - Lines 8-15: zero rising, one falling
// - Flags set on edge, held until cleared
module port_input_and_edge_select (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [31:0] adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	output reg         err_o,
	// Port 3 pads
	input  wire [7:0]  port3_pin_i,
	output reg  [7:0]  port3_out_o,
	output reg  [7:0]  port3_oe_o,
	output reg  [7:0]  port3_pullup_o,
	// External interrupt pins and flags
	input  wire [15:0] ext_irq_pin_i,
	output reg  [15:0] irq_edge_flag_o
);
	reg  [7:0]  pin_sync1_q;
	reg  [7:0]  pin_sync2_q;
	reg  [7:0]  pol_low_q;
	reg  [7:0]  pol_high_q;
	reg  [15:0] flag_q;
	reg  [15:0] flag_d;
	reg  [7:0]  out_latch_q;
	reg  [7:0]  dir_q;
	reg  [31:0] rdata_d;
	reg         hit_d;
	wire [15:0] edge_w;
	wire [15:0] pol_w;
	wire        req_w;
	wire        wr_w;
	wire        rd_w;
	wire [7:0]  idx_w;
	wire [8:0]  wi_w;
	wire        mapped_w;
	wire        wr_pol_low_w;
	wire        wr_pol_high_w;
	wire        wr_flag_low_w;
	wire        wr_flag_high_w;
	wire        wr_latch_w;
	wire        wr_dir_w;

	// Word index of a byte address; nonzero high bits mean no hit
	function [8:0] word_index;
		input [31:0] adr;
		begin
			word_index = {(|adr[31:10]) | (|adr[1:0]), adr[9:2]};
		end
	endfunction

	function is_mapped;
		input [8:0] wi;
		begin
			is_mapped = ~wi[8] && (wi[7:0] >= `IDX_PORT3_PIN_STATE) &&
				(wi[7:0] <= `IDX_PORT3_DIRECTION);
		end
	endfunction

	// One register selected by the current word index
	function reg_is;
		input [7:0] idx;
		input [7:0] target;
		begin
			reg_is = (idx == target);
		end
	endfunction

	assign wi_w     = word_index(adr_i);
	assign mapped_w = is_mapped(wi_w);
	assign req_w    = cyc_i & stb_i & ~ack_o & ~err_o;
	assign idx_w    = wi_w[7:0];
	assign wr_w     = req_w & we_i & sel_i[0] & mapped_w;
	assign rd_w     = req_w & ~we_i;
	assign pol_w    = {pol_high_q, pol_low_q};

	// Per-register write strobes
	assign wr_pol_low_w   = wr_w & reg_is(idx_w, `IDX_IRQ_EDGE_POL_LOW);
	assign wr_pol_high_w  = wr_w & reg_is(idx_w, `IDX_IRQ_EDGE_POL_HIGH);
	assign wr_flag_low_w  = wr_w & reg_is(idx_w, `IDX_IRQ_EDGE_FLAG_LOW);
	assign wr_flag_high_w = wr_w & reg_is(idx_w, `IDX_IRQ_EDGE_FLAG_HIGH);
	assign wr_latch_w     = wr_w & reg_is(idx_w, `IDX_PORT3_OUT_LATCH);
	assign wr_dir_w       = wr_w & reg_is(idx_w, `IDX_PORT3_DIRECTION);

	// Port 3 pins pass two flip-flops before being read
	always @(posedge clk_i) begin
		if (rst_i) begin
			pin_sync1_q <= 8'h00;
			pin_sync2_q <= 8'h00;
		end else begin
			pin_sync1_q <= port3_pin_i;
			pin_sync2_q <= pin_sync1_q;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_edge
			edge_detect u_edge (
				.clk_i     (clk_i),
				.rst_i     (rst_i),
				.pin_i     (ext_irq_pin_i[g]),
				.falling_i (pol_w[g]),
				.edge_o    (edge_w[g])
			);
		end
	endgenerate

	// Flags: write one to clear; a new edge in the same cycle wins
	always @* begin
		flag_d = flag_q;
		if (wr_flag_low_w)
			flag_d[7:0] = flag_q[7:0] & ~dat_i[7:0];
		if (wr_flag_high_w)
			flag_d[15:8] = flag_q[15:8] & ~dat_i[7:0];
		flag_d = flag_d | edge_w;
	end

	// Sticky flags
	always @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= {2{`RST_IRQ_EDGE_FLAG}};
		end else begin
			flag_q <= flag_d;
		end
	end

	// Polarity for lines 0-7
	always @(posedge clk_i) begin
		if (rst_i) begin
			pol_low_q <= `RST_IRQ_EDGE_POL;
		end else if (wr_pol_low_w) begin
			pol_low_q <= dat_i[7:0];
		end
	end

	// Polarity for lines 8-15, usable as plain storage where they have no pins
	always @(posedge clk_i) begin
		if (rst_i) begin
			pol_high_q <= `RST_IRQ_EDGE_POL;
		end else if (wr_pol_high_w) begin
			pol_high_q <= dat_i[7:0];
		end
	end

	// Port 3 output latch
	always @(posedge clk_i) begin
		if (rst_i) begin
			out_latch_q <= `RST_PORT3_OUT_LATCH;
		end else if (wr_latch_w) begin
			out_latch_q <= dat_i[7:0];
		end
	end

	// Port 3 direction, one means driven
	always @(posedge clk_i) begin
		if (rst_i) begin
			dir_q <= `RST_PORT3_DIRECTION;
		end else if (wr_dir_w) begin
			dir_q <= dat_i[7:0];
		end
	end

	// Read mux; pin state register ignores writes
	always @* begin
		rdata_d = 32'h00000000;
		hit_d   = is_mapped(word_index(adr_i));
		case (idx_w)
			`IDX_PORT3_PIN_STATE:    rdata_d[7:0] = pin_sync2_q;
			`IDX_IRQ_EDGE_POL_LOW:   rdata_d[7:0] = pol_low_q;
			`IDX_IRQ_EDGE_POL_HIGH:  rdata_d[7:0] = pol_high_q;
			`IDX_IRQ_EDGE_FLAG_LOW:  rdata_d[7:0] = flag_q[7:0];
			`IDX_IRQ_EDGE_FLAG_HIGH: rdata_d[7:0] = flag_q[15:8];
			`IDX_PORT3_OUT_LATCH:    rdata_d[7:0] = out_latch_q;
			`IDX_PORT3_DIRECTION:    rdata_d[7:0] = dir_q;
			default:                 rdata_d      = 32'h00000000;
		endcase
		if (!hit_d)
			rdata_d = 32'h00000000;
	end

	// Bus answer one cycle after the request, dropped the next cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= req_w & is_mapped(word_index(adr_i));
			err_o <= req_w & ~is_mapped(word_index(adr_i));
			dat_o <= rd_w ? rdata_d : 32'h00000000;
		end
	end

	// Pad drive: output where direction set, else pullup follows latch
	always @(posedge clk_i) begin
		if (rst_i) begin
			port3_out_o     <= `RST_PORT3_OUT_LATCH;
			port3_oe_o      <= `RST_PORT3_DIRECTION;
			port3_pullup_o  <= 8'h00;
			irq_edge_flag_o <= 16'h0000;
		end else begin
			port3_out_o     <= out_latch_q;
			port3_oe_o      <= dir_q;
			port3_pullup_o  <= ~dir_q & out_latch_q;
			irq_edge_flag_o <= flag_q;
		end
	end
endmodule

`default_nettype wire

// [port_edge_consts.vh]
// Constants for the port 3 input and external interrupt edge select block.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef PORT_EDGE_CONSTS_VH
`define PORT_EDGE_CONSTS_VH

// Register indices as printed; byte address is four times the index
`define IDX_PORT3_PIN_STATE      8'h0B
`define IDX_IRQ_EDGE_POL_LOW     8'h0C
`define IDX_IRQ_EDGE_POL_HIGH    8'h0D
// Extra registers for flags and port 3 control
`define IDX_IRQ_EDGE_FLAG_LOW    8'h0E
`define IDX_IRQ_EDGE_FLAG_HIGH   8'h0F
`define IDX_PORT3_OUT_LATCH      8'h10
`define IDX_PORT3_DIRECTION      8'h11

`define RST_IRQ_EDGE_POL         8'h00
`define RST_IRQ_EDGE_FLAG        8'h00
`define RST_PORT3_OUT_LATCH      8'hFF
`define RST_PORT3_DIRECTION      8'h00

`endif

// [edge_detect.v]
// Synchroniser and edge detector for one external interrupt line.
// Assumes the pin is asynchronous to clk_i; polarity comes from same-domain logic.
`timescale 1ns/100ps
`default_nettype none

module edge_detect (
	// Clock and reset
	input  wire clk_i,
	input  wire rst_i,
	// Line and polarity
	input  wire pin_i,
	input  wire falling_i,
	// One-cycle edge pulse
	output wire edge_o
);
	reg sync1_q;
	reg sync2_q;
	reg       prev_q;
	reg [2:0] fill_q;

	always @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
			fill_q  <= 3'h0;
		end else begin
			sync1_q <= pin_i;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
			fill_q  <= {fill_q[1:0], 1'h1};
		end
	end

	// Compare only real samples: a pin high at reset gives no false edge,
	// but a pin change before the first sample after reset is not seen
	assign edge_o = fill_q[2] & (falling_i ? (prev_q & ~sync2_q) : (~prev_q & sync2_q));
endmodule

`default_nettype wire

// [port_input_and_edge_select_checker.sv]
// Checker for the port 3 and edge select block, bound to its top module.
// Assumes pins settle between edges and one master on the bus.
`timescale 1ns/100ps
`default_nettype none
module port_input_and_edge_select_checker (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Bus request and answer
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic        ack_o,
	input wire logic        err_o,
	input wire logic [31:0] dat_o,
	// Pads and interrupt lines
	input wire logic [7:0]  port3_out_o,
	input wire logic [7:0]  port3_oe_o,
	input wire logic [7:0]  port3_pullup_o,
	input wire logic [15:0] ext_irq_pin_i,
	input wire logic [15:0] irq_edge_flag_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_answer_next: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
		else $error("request not answered");
	a_answer_pulse: assert property (ack_o || err_o |=> !ack_o && !err_o)
		else $error("answer too long");
	a_data_idle: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("data outside ack");
	a_data_width: assert property (ack_o |-> dat_o[31:8] == 24'h0)
		else $error("upper data set");
	a_pull_on: assert property (!$past(rst_i)
		|-> (port3_pullup_o & ~port3_oe_o) == (port3_out_o & ~port3_oe_o))
		else $error("pullup missing");
	a_pull_off: assert property (!$past(rst_i)
		|-> (port3_pullup_o & (port3_oe_o | ~port3_out_o)) == 8'h00)
		else $error("pullup not off");
	a_flag_hold: assert property (!(cyc_i && we_i) [*2]
		|=> (irq_edge_flag_o & $past(irq_edge_flag_o)) == $past(irq_edge_flag_o))
		else $error("flag lost");
	a_flag_cause: assert property ((irq_edge_flag_o & ~$past(irq_edge_flag_o)
		& ~($past(ext_irq_pin_i, 4) ^ $past(ext_irq_pin_i, 5))) == 16'h0000)
		else $error("flag without edge");
endmodule
bind port_input_and_edge_select port_input_and_edge_select_checker checker_i (
	.clk_i           (clk_i),
	.rst_i           (rst_i),
	.cyc_i           (cyc_i),
	.stb_i           (stb_i),
	.we_i            (we_i),
	.ack_o           (ack_o),
	.err_o           (err_o),
	.dat_o           (dat_o),
	.port3_out_o     (port3_out_o),
	.port3_oe_o      (port3_oe_o),
	.port3_pullup_o  (port3_pullup_o),
	.ext_irq_pin_i   (ext_irq_pin_i),
	.irq_edge_flag_o (irq_edge_flag_o)
);
`default_nettype wire

// [pin_model.sv]
// Board model for port 3: pad drive, board drive and a wandering float.
// Assumes the bench chooses which pads the board drives.
`timescale 1ns/100ps
`default_nettype none
module pin_model (
	// Clock
	input  wire logic       clk_i,
	// Pad drive from the block
	input  wire logic [7:0] out_i,
	input  wire logic [7:0] oe_i,
	input  wire logic [7:0] pull_i,
	// Board drive chosen by the bench
	input  wire logic [7:0] ext_en_i,
	input  wire logic [7:0] ext_i,
	// Resulting pad levels
	output logic      [7:0] pin_o
);
	logic tog_q = 1'h0;
	always @(posedge clk_i) tog_q <= ~tog_q;
	// Undriven pad without pullup wanders
	assign pin_o = oe_i & out_i | ~oe_i & (ext_en_i & ext_i | ~ext_en_i & (pull_i | {8{tog_q}}));
endmodule
`default_nettype wire

// [port_input_and_edge_select_bench.sv]
// Bench for the port 3 and edge select block over classic Wishbone.
// Assumes the pin model as board; interrupt pins held low through reset.
`timescale 1ns/100ps
`default_nettype none
module port_input_and_edge_select_bench;
	logic        clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, er;
	logic        ack_o, err_o;
	logic [3:0]  sel_i = 4'hF;
	logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, rd;
	logic [7:0]  port3_pin_i, port3_out_o, port3_oe_o, port3_pullup_o, ext_en = 8'h0, ext = 8'h0;
	logic [15:0] ext_irq_pin_i = 16'h0, irq_edge_flag_o;
	int          n_mismatch = 0, checks_done = 0;
	port_input_and_edge_select port_input_and_edge_select_i (
		.clk_i           (clk_i),
		.rst_i           (rst_i),
		.cyc_i           (cyc_i),
		.stb_i           (stb_i),
		.we_i            (we_i),
		.adr_i           (adr_i),
		.sel_i           (sel_i),
		.dat_i           (dat_i),
		.dat_o           (dat_o),
		.ack_o           (ack_o),
		.err_o           (err_o),
		.port3_pin_i     (port3_pin_i),
		.port3_out_o     (port3_out_o),
		.port3_oe_o      (port3_oe_o),
		.port3_pullup_o  (port3_pullup_o),
		.ext_irq_pin_i   (ext_irq_pin_i),
		.irq_edge_flag_o (irq_edge_flag_o)
	);
	pin_model pin_model_i (.clk_i(clk_i), .out_i(port3_out_o), .oe_i(port3_oe_o),
		.pull_i(port3_pullup_o), .ext_en_i(ext_en), .ext_i(ext), .pin_o(port3_pin_i));
	initial forever #2.5 clk_i = ~clk_i;
	task print_verdict;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task cmp(input logic [31:0] g, e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wb(input logic w, input logic [31:0] a, d);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'h1 && err_o !== 1'h1);
		rd = dat_o;
		er = err_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task rdc(input logic [31:0] a, e);
		wb(1'h0, a, 32'h0);
		cmp(rd, e);
	endtask
	task t_reset;
		rdc(32'h30, 32'h0);
		rdc(32'h34, 32'h0);
		wb(1'h0, 32'h80, 32'h0);
		cmp({31'h0, er}, 32'h1);
		cmp({24'h0, port3_pullup_o}, 32'hFF);
		cmp({24'h0, port3_oe_o}, 32'h00);
		cmp({16'h0, irq_edge_flag_o}, 32'h0);
	endtask
	task t_pads;
		wb(1'h1, 32'h40, 32'h0D);
		wb(1'h1, 32'h44, 32'h03);
		ext_en <= 8'hF0;
		ext <= 8'hA0;
		wb(1'h1, 32'h2C, 32'h55);
		// Write with the low byte lane off leaves the latch alone
		sel_i <= 4'hE;
		wb(1'h1, 32'h40, 32'hFF);
		sel_i <= 4'hF;
		repeat (4) @(posedge clk_i);
		cmp({24'h0, port3_pullup_o}, 32'h0C);
		cmp({24'h0, port3_out_o}, 32'h0D);
		cmp({24'h0, port3_oe_o}, 32'h03);
		rdc(32'h40, 32'h0D);
		rdc(32'h2C, 32'hAD);
	endtask
	task t_edges;
		wb(1'h1, 32'h30, 32'h01);
		// High register sets edges for lines 8 and 9 as for lines 0 and 1; its flags are never written
		wb(1'h1, 32'h34, 32'h01);
		rdc(32'h34, 32'h01);
		ext_irq_pin_i <= 16'h0303;
		repeat (8) @(posedge clk_i);
		cmp({16'h0, irq_edge_flag_o}, 32'h0202);
		ext_irq_pin_i <= 16'h0;
		repeat (8) @(posedge clk_i);
		cmp({16'h0, irq_edge_flag_o}, 32'h0303);
		wb(1'h1, 32'h38, 32'hFF);
		repeat (2) @(posedge clk_i);
		cmp({16'h0, irq_edge_flag_o}, 32'h0300);
	endtask
	task t_mid_reset;
		rst_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		cmp({16'h0, irq_edge_flag_o}, 32'h0);
		rdc(32'h30, 32'h0);
		rdc(32'h34, 32'h0);
	endtask
	initial begin
		repeat (3000) @(posedge clk_i);
		n_mismatch++;
		print_verdict;
	end
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		t_reset;
		t_pads;
		t_edges;
		t_mid_reset;
		print_verdict;
	end
endmodule
`default_nettype wire
